// ---- core/flash_prot_consts.svh ----
`ifndef FLASH_PROT_CONSTS_SVH
`define FLASH_PROT_CONSTS_SVH

// Register byte offsets
`define KEY_OFS        4'h0
`define STAT_OFS       4'h4
`define CTRL_OFS       4'h8
`define OPTCR_OFS      4'hC

// Option keys
`define OPT_KEY1       32'h08192A3B
`define OPT_KEY2       32'h4C5D6E7F

// Readout level codes
`define RDP_L0         8'hAA
`define RDP_L2         8'hCC
`define RDP_ERASED     8'hFF

// Status bits
`define ST_BUSY_BIT    16
`define ST_READ_PROTECT_ERROR_FLAG_BIT   8
`define ST_WRERR_BIT   4

// Control bits
`define CT_SER_BIT     1
`define CT_MER_BIT     2
`define CT_SNB_LSB     3
`define CT_SNB_MSB     6
`define CT_START_BIT   16

// Option control bits
`define OC_LOCK_BIT    0
`define OC_START_BIT   1
`define OC_BOR_LSB     2
`define OC_BOR_MSB     3
`define OC_RDP_LSB     8
`define OC_RDP_MSB     15
`define OC_UNP_LSB     16
`define OC_UNP_MSB     23
`define OC_SPR_BIT     31

// Option reset values
`define OPT_RST_BOR    2'h3
`define OPT_RST_UNP    8'hFF

// Operation times in ns, clock period in ns
`define CLK_NS         40
`define MASS_NS        800
`define SECT_NS        400
`define PROG_NS        120
`define CFG_ERASE_NS   200
`define CFG_PROG_NS    200

`endif

// ---- core/flash_prot_pkg.sv ----
package flash_prot_pkg;

    typedef enum logic [2:0] {
        REG_MAIN, REG_SYSMEM, REG_RESERVED, REG_CFG, REG_OTP
    } region_t;

    typedef enum logic [1:0] {BOOT_FLASH, BOOT_RAM, BOOT_SYSMEM} boot_t;

    typedef enum logic [2:0] {
        OP_NONE, OP_MASS, OP_SECT, OP_PROG, OP_CFG_ERASE, OP_CFG_PROG
    } nvm_op_t;

    typedef struct packed {
        logic       spr;
        logic [7:0] unprot;
        logic [7:0] readout_level_byte;
        logic [1:0] bor;
    } opt_t;

    typedef struct packed {
        logic       valid;
        nvm_op_t    op;
        logic [3:0] sector;
    } nvm_cmd_t;

    typedef struct packed {
        logic       req;
        logic       write;
        logic       ibus;
        region_t    region;
        logic [3:0] sector;
        logic       otp_locked;
    } acc_req_t;

endpackage

// ---- core/flash_protection_logic.sv ----
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "flash_prot_consts.svh"
module flash_protection_logic #(
    parameter int NSECT = 8
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic [3:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    output logic [31:0]                  avs_readdata,
    output logic                         avs_waitrequest,
    input  wire logic                    debug_connected,
    input  wire flash_prot_pkg::boot_t   boot_src,
    input  wire flash_prot_pkg::acc_req_t acc,
    output logic                         acc_ready,
    output logic                         acc_ok,
    output logic                         acc_bus_err,
    output flash_prot_pkg::nvm_cmd_t     nvm_cmd,
    output flash_prot_pkg::opt_t         opt_active,
    output logic                         debug_disable,
    output logic                         boot_ram_forbid
);

    localparam int MASS_CYC = (`MASS_NS + `CLK_NS - 1) / `CLK_NS;
    localparam int SECT_CYC = (`SECT_NS + `CLK_NS - 1) / `CLK_NS;
    localparam int PROG_CYC = (`PROG_NS + `CLK_NS - 1) / `CLK_NS;
    localparam int CFGE_CYC = (`CFG_ERASE_NS + `CLK_NS - 1) / `CLK_NS;
    localparam int CFGP_CYC = (`CFG_PROG_NS + `CLK_NS - 1) / `CLK_NS;

    initial begin
        if (NSECT < 1 || NSECT > 8) begin
            $error("NSECT must be 1 to 8");
        end
    end

    typedef enum logic [2:0] {
        ST_IDLE, ST_MASS, ST_CFG_ERASE, ST_CFG_PROG, ST_ERASE, ST_PROG
    } state_t;

    function automatic logic [1:0] level_of(input logic [7:0] readout_level_byte);
        if (readout_level_byte == `RDP_L0) begin
            return 2'h0;
        end else if (readout_level_byte == `RDP_L2) begin
            return 2'h2;
        end
        return 2'h1;
    endfunction

    // Protected sectors under either mode; both block erase and program
    function automatic logic [7:0] prot_of(input flash_prot_pkg::opt_t o);
        return o.spr ? o.unprot : ~o.unprot;
    endfunction

    state_t                 state_r;
    logic [9:0]             cnt_r;
    flash_prot_pkg::opt_t   opt_r;
    flash_prot_pkg::opt_t   optcr_r;
    logic                   lock_r;
    logic                   key_stage_r;
    logic                   wrerr_r;
    logic                   read_protect_error_flag_r;
    logic                   ack_r;
    logic [31:0]            rdata_r;
    flash_prot_pkg::nvm_cmd_t cmd_r;
    logic [1:0]             level;
    logic                   intrusion;
    logic [7:0]             prot;
    logic                   busy;
    logic                   wr_go;
    logic                   ctrl_wr;
    logic                   opt_wr;
    logic                   erase_req;
    logic                   erase_bad;
    logic                   opt_req;
    logic                   opt_bad;
    logic                   prog_req;
    logic                   prog_bad;
    logic                   rd_pcrop;
    logic                   lower_10;
    logic [3:0]             sector_number_field;
    logic                   mass_erase_request;
    logic                   sector_erase_request;

    assign level     = level_of(opt_r.readout_level_byte);
    assign prot      = prot_of(opt_r);
    assign busy      = (state_r != ST_IDLE);
    assign intrusion = (level != 2'h0)
                     && (debug_connected || boot_src != flash_prot_pkg::BOOT_FLASH);
    assign debug_disable   = (level == 2'h2);
    assign boot_ram_forbid = (level == 2'h2);
    assign opt_active      = opt_r;
    assign nvm_cmd         = cmd_r;

    // Bus answer one cycle after the request is seen
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign avs_readdata    = rdata_r;
    assign wr_go   = avs_write && ack_r;
    assign ctrl_wr = wr_go && avs_address == `CTRL_OFS;
    assign opt_wr  = wr_go && avs_address == `OPTCR_OFS && !lock_r;

    assign sector_number_field = avs_writedata[`CT_SNB_MSB:`CT_SNB_LSB];
    assign mass_erase_request = avs_writedata[`CT_MER_BIT];
    assign sector_erase_request = avs_writedata[`CT_SER_BIT];
    assign erase_req = ctrl_wr && avs_writedata[`CT_START_BIT] && !busy && (mass_erase_request || sector_erase_request);
    assign erase_bad = (mass_erase_request && sector_erase_request)
                     || (sector_erase_request && sector_number_field >= 4'(NSECT))
                     || (mass_erase_request && |prot[NSECT-1:0])
                     || (sector_erase_request && sector_number_field < 4'(NSECT) && prot[sector_number_field[2:0]])
                     || intrusion;

    assign lower_10 = level == 2'h1 && level_of(optcr_r.readout_level_byte) == 2'h0;
    assign opt_req  = opt_wr && avs_writedata[`OC_START_BIT] && !busy;
    assign opt_bad  = (level == 2'h2)
                    || (opt_r.spr && !lower_10
                        && (!optcr_r.spr || |(opt_r.unprot & ~optcr_r.unprot)));

    assign prog_req = acc.req && acc.write && !busy;
    assign prog_bad = acc.region != flash_prot_pkg::REG_MAIN
                      && acc.region != flash_prot_pkg::REG_OTP
                    || (acc.region == flash_prot_pkg::REG_MAIN
                        && (acc.sector >= 4'(NSECT) || prot[acc.sector[2:0]]))
                    || (acc.region == flash_prot_pkg::REG_OTP && acc.otp_locked)
                    || intrusion;

    assign rd_pcrop = acc.req && !acc.write && !acc.ibus && opt_r.spr
                    && acc.region == flash_prot_pkg::REG_MAIN
                    && acc.sector < 4'(NSECT) && opt_r.unprot[acc.sector[2:0]];

    // Reads need no busy wait; programs wait for the engine
    assign acc_ready   = !acc.write || !busy;
    assign acc_bus_err = acc.req && !acc.write
                       && ((intrusion && acc.region != flash_prot_pkg::REG_CFG)
                           || rd_pcrop);
    assign acc_ok      = acc.req && acc_ready && !acc_bus_err
                       && !(acc.write && prog_bad);

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 32'h0;
        end else if (avs_read && !ack_r) begin
            rdata_r <= 32'h0;
            unique case (avs_address)
                `STAT_OFS: begin
                    rdata_r[`ST_BUSY_BIT]  <= busy;
                    rdata_r[`ST_READ_PROTECT_ERROR_FLAG_BIT] <= read_protect_error_flag_r;
                    rdata_r[`ST_WRERR_BIT] <= wrerr_r;
                end
                `OPTCR_OFS: begin
                    rdata_r[`OC_LOCK_BIT]             <= lock_r;
                    rdata_r[`OC_BOR_MSB:`OC_BOR_LSB]  <= optcr_r.bor;
                    rdata_r[`OC_RDP_MSB:`OC_RDP_LSB]  <= optcr_r.readout_level_byte;
                    rdata_r[`OC_UNP_MSB:`OC_UNP_LSB]  <= optcr_r.unprot;
                    rdata_r[`OC_SPR_BIT]              <= optcr_r.spr;
                end
                default: rdata_r <= 32'h0;
            endcase
        end
    end

    // Key sequence; a wrong second write restarts it
    always_ff @(posedge clk) begin
        if (rst) begin
            lock_r      <= 1'b1;
            key_stage_r <= 1'b0;
        end else if (wr_go && avs_address == `KEY_OFS) begin
            if (!key_stage_r && avs_writedata == `OPT_KEY1) begin
                key_stage_r <= 1'b1;
            end else begin
                key_stage_r <= 1'b0;
                if (key_stage_r && avs_writedata == `OPT_KEY2) begin
                    lock_r <= 1'b0;
                end
            end
        end else if (wr_go) begin
            key_stage_r <= 1'b0;
            if (opt_wr && avs_writedata[`OC_LOCK_BIT]) begin
                lock_r <= 1'b1;
            end
        end
    end

    // Software copy of the option value
    always_ff @(posedge clk) begin
        if (rst) begin
            optcr_r <= '{spr: 1'b0, unprot: `OPT_RST_UNP, readout_level_byte: `RDP_L0, bor: `OPT_RST_BOR};
        end else if (opt_req && opt_bad) begin
            // Refused change: software copy falls back to the active bytes
            optcr_r <= opt_r;
        end else if (opt_wr && !busy) begin
            optcr_r.bor    <= avs_writedata[`OC_BOR_MSB:`OC_BOR_LSB];
            optcr_r.readout_level_byte    <= avs_writedata[`OC_RDP_MSB:`OC_RDP_LSB];
            optcr_r.unprot <= avs_writedata[`OC_UNP_MSB:`OC_UNP_LSB];
            optcr_r.spr    <= avs_writedata[`OC_SPR_BIT];
        end
    end

    // Active option bytes; reset loads the option reset values, else only configuration erase and program change them
    always_ff @(posedge clk) begin
        if (rst) begin
            opt_r <= '{spr: 1'b0, unprot: `OPT_RST_UNP, readout_level_byte: `RDP_L0, bor: `OPT_RST_BOR};
        end else if (state_r == ST_CFG_ERASE && cnt_r == 10'h0) begin
            opt_r <= '{spr: 1'b0, unprot: `OPT_RST_UNP, readout_level_byte: `RDP_ERASED,
                       bor: `OPT_RST_BOR};
        end else if (state_r == ST_CFG_PROG && cnt_r == 10'h0) begin
            opt_r <= optcr_r;
        end
    end

    // Operation engine
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cnt_r   <= 10'h0;
            cmd_r   <= '{valid: 1'b0, op: flash_prot_pkg::OP_NONE, sector: 4'h0};
        end else begin
            cmd_r.valid <= 1'b0;
            if (cnt_r != 10'h0) begin
                cnt_r <= cnt_r - 10'h1;
            end
            unique case (state_r)
                ST_IDLE: begin
                    if (opt_req && !opt_bad) begin
                        cmd_r <= '{valid: 1'b1, op: flash_prot_pkg::OP_CFG_ERASE, sector: 4'h0};
                        state_r <= ST_CFG_ERASE;
                        cnt_r   <= 10'(CFGE_CYC - 1);
                        if (lower_10) begin
                            // Code area goes before protection is lifted
                            cmd_r.op <= flash_prot_pkg::OP_MASS;
                            state_r  <= ST_MASS;
                            cnt_r    <= 10'(MASS_CYC - 1);
                        end
                    end else if (erase_req && !erase_bad) begin
                        cmd_r <= '{valid: 1'b1,
                                   op: mass_erase_request ? flash_prot_pkg::OP_MASS : flash_prot_pkg::OP_SECT,
                                   sector: sector_number_field};
                        state_r <= ST_ERASE;
                        cnt_r   <= mass_erase_request ? 10'(MASS_CYC - 1) : 10'(SECT_CYC - 1);
                    end else if (prog_req && !prog_bad) begin
                        cmd_r <= '{valid: 1'b1, op: flash_prot_pkg::OP_PROG,
                                   sector: acc.sector};
                        state_r <= ST_PROG;
                        cnt_r   <= 10'(PROG_CYC - 1);
                    end
                end
                ST_MASS: begin
                    if (cnt_r == 10'h0) begin
                        cmd_r   <= '{valid: 1'b1, op: flash_prot_pkg::OP_CFG_ERASE,
                                     sector: 4'h0};
                        state_r <= ST_CFG_ERASE;
                        cnt_r   <= 10'(CFGE_CYC - 1);
                    end
                end
                ST_CFG_ERASE: begin
                    if (cnt_r == 10'h0) begin
                        cmd_r   <= '{valid: 1'b1, op: flash_prot_pkg::OP_CFG_PROG,
                                     sector: 4'h0};
                        state_r <= ST_CFG_PROG;
                        cnt_r   <= 10'(CFGP_CYC - 1);
                    end
                end
                ST_CFG_PROG, ST_ERASE, ST_PROG: begin
                    if (cnt_r == 10'h0) begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Error flags: hardware set wins over the write-one clear
    always_ff @(posedge clk) begin
        if (rst) begin
            wrerr_r <= 1'b0;
        end else if ((opt_req && opt_bad) || (erase_req && erase_bad)
                     || (prog_req && prog_bad)) begin
            wrerr_r <= 1'b1;
        end else if (wr_go && avs_address == `STAT_OFS && avs_writedata[`ST_WRERR_BIT]) begin
            wrerr_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            read_protect_error_flag_r <= 1'b0;
        end else if (rd_pcrop) begin
            read_protect_error_flag_r <= 1'b1;
        end else if (wr_go && avs_address == `STAT_OFS && avs_writedata[`ST_READ_PROTECT_ERROR_FLAG_BIT]) begin
            read_protect_error_flag_r <= 1'b0;
        end
    end

    sequence opt_start_s;
        state_r == ST_IDLE && opt_req && !opt_bad && !lower_10;
    endsequence

    sequence cfg_walk_s;
        state_r == ST_CFG_ERASE [*5] ##1 state_r == ST_CFG_PROG;
    endsequence

    opt_seq_a: assert property (@(posedge clk) disable iff (rst)
        opt_start_s |=> cfg_walk_s)
        else $error("option change skipped configuration erase");

    mass_low_a: assert property (@(posedge clk) disable iff (rst)
        state_r == ST_IDLE && opt_req && !opt_bad && lower_10
        |=> state_r == ST_MASS && cmd_r.op == flash_prot_pkg::OP_MASS)
        else $error("no mass erase on level drop");

    no_mass_a: assert property (@(posedge clk) disable iff (rst)
        state_r == ST_IDLE && opt_req && !lower_10 |=> state_r != ST_MASS)
        else $error("mass erase without level drop");

    lvl2_keep_a: assert property (@(posedge clk) disable iff (rst)
        level == 2'h2 |=> level == 2'h2 && opt_r == $past(opt_r))
        else $error("level 2 options changed");

    lvl2_err_a: assert property (@(posedge clk) disable iff (rst)
        level == 2'h2 && opt_req |=> wrerr_r && state_r == ST_IDLE)
        else $error("level 2 option change not flagged");

    intr_block_a: assert property (@(posedge clk) disable iff (rst)
        intrusion && acc.req |-> !acc_ok)
        else $error("access granted under intrusion");

    lvl0_open_a: assert property (@(posedge clk) disable iff (rst)
        level == 2'h0 && acc.req && !acc.write && !opt_r.spr |-> acc_ok)
        else $error("level 0 read refused");

    erase_err_a: assert property (@(posedge clk) disable iff (rst)
        erase_req && state_r == ST_IDLE && (mass_erase_request && sector_erase_request) |=> wrerr_r && state_r == ST_IDLE)
        else $error("bad erase not flagged");

    prot_prog_a: assert property (@(posedge clk) disable iff (rst)
        prog_req && acc.region == flash_prot_pkg::REG_MAIN && acc.sector < 4'(NSECT)
        && prot[acc.sector[2:0]] |=> wrerr_r && state_r != ST_PROG)
        else $error("protected sector programmed");

    read_protect_error_flag_set_a: assert property (@(posedge clk) disable iff (rst)
        rd_pcrop |-> acc_bus_err ##1 read_protect_error_flag_r)
        else $error("code protected read not flagged");

    busy_done_a: assert property (@(posedge clk) disable iff (rst)
        state_r == ST_IDLE ##1 state_r == ST_PROG |-> ##[1:8] state_r == ST_IDLE)
        else $error("busy did not clear");

endmodule // flash_protection_logic

// ---- dv/flash_sw_model.sv ----
`timescale 1ns/10ps
module flash_sw_model (
    input  wire logic                 clk,
    input  wire logic                 acc_ready,
    input  wire logic                 acc_ok,
    input  wire logic                 acc_bus_err,
    output flash_prot_pkg::acc_req_t  acc,
    output logic                      debug_connected,
    output flash_prot_pkg::boot_t     boot_src
);
    initial begin
        acc = '0;
        debug_connected = 1'b0;
        boot_src = flash_prot_pkg::BOOT_FLASH;
    end
    // Debugger and boot source are levels that the scenario moves between accesses
    task automatic set_path(input logic dbg, input flash_prot_pkg::boot_t bs);
        @(posedge clk);
        debug_connected <= dbg;
        boot_src <= bs;
    endtask
    // Held until ready; released fields go inverse so a stale value can never match
    task automatic access(input logic wr, input logic ib, input flash_prot_pkg::region_t rg,
                          input logic [3:0] sec, output logic ok, output logic err);
        int i;
        ok = 1'bx;
        err = 1'bx;
        @(posedge clk);
        acc <= '{req:1'b1, write:wr, ibus:ib, region:rg, sector:sec, otp_locked:1'b1};
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (acc_ready === 1'b1) begin
                ok = acc_ok;
                err = acc_bus_err;
                break;
            end
        end
        acc <= flash_prot_pkg::acc_req_t'({1'b0, ~acc[9:0]});
    endtask
endmodule // flash_sw_model

// ---- dv/tb.sv ----
`timescale 1ns/10ps
`include "flash_prot_consts.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb;
    logic                      clk = 1'b0;
    logic                      rst = 1'b1;
    logic [3:0]                avs_address = 4'h0;
    logic                      avs_read = 1'b0;
    logic                      avs_write = 1'b0;
    logic [31:0]               avs_writedata = 32'h0;
    logic [31:0]               avs_readdata, rd;
    logic                      avs_waitrequest, acc_ready, acc_ok, acc_bus_err;
    logic                      debug_connected, debug_disable, boot_ram_forbid, ok, err;
    flash_prot_pkg::boot_t     boot_src;
    flash_prot_pkg::acc_req_t  acc;
    flash_prot_pkg::nvm_cmd_t  nvm_cmd;
    flash_prot_pkg::opt_t      opt_active;
    flash_prot_pkg::region_t   rgs [5] = '{flash_prot_pkg::REG_MAIN, flash_prot_pkg::REG_SYSMEM,
        flash_prot_pkg::REG_RESERVED, flash_prot_pkg::REG_CFG, flash_prot_pkg::REG_OTP};
    logic [31:0]               ers [4] = '{32'h10006, 32'h10042, 32'h10004, 32'h10002};
    int                        num_errors = 0;
    int                        n_compared = 0;
    int                        mass_n = 0;
    logic [3:0]                last_sec = 4'hF;
    always #20 clk = ~clk;
    always @(posedge clk) begin
        if (nvm_cmd.valid === 1'b1 && nvm_cmd.op === flash_prot_pkg::OP_MASS) begin
            mass_n++;
        end
        if (nvm_cmd.valid === 1'b1) begin
            last_sec <= nvm_cmd.sector;
        end
    end
    flash_protection_logic #(.NSECT(8)) dut (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .debug_connected(debug_connected), .boot_src(boot_src), .acc(acc),
        .acc_ready(acc_ready), .acc_ok(acc_ok), .acc_bus_err(acc_bus_err), .nvm_cmd(nvm_cmd),
        .opt_active(opt_active), .debug_disable(debug_disable),
        .boot_ram_forbid(boot_ram_forbid));
    flash_sw_model sw (.clk(clk), .acc_ready(acc_ready), .acc_ok(acc_ok),
        .acc_bus_err(acc_bus_err), .acc(acc), .debug_connected(debug_connected),
        .boot_src(boot_src));
    task automatic summarize;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Idle cycle before each request keeps one assignment per signal per step
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) begin
                rd = avs_readdata;
                break;
            end
        end
        if (i == 20) begin
            num_errors++;
            summarize();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    function automatic logic [31:0] ow(logic s, logic [7:0] u, logic [7:0] r, logic [1:0] b);
        return {s, 7'h00, u, r, 4'h0, b, 2'b00};
    endfunction
    task automatic wait_idle;
        int i;
        for (i = 0; i < 100; i++) begin
            bus(1'b0, `STAT_OFS, 32'h0);
            if (rd[`ST_BUSY_BIT] === 1'b0) break;
        end
        if (i == 100) begin
            num_errors++;
            summarize();
        end
    endtask
    task automatic opt_chg(input logic [31:0] v);
        wait_idle();
        bus(1'b1, `OPTCR_OFS, v);
        bus(1'b1, `OPTCR_OFS, v | 32'h2);
        wait_idle();
    endtask
    task automatic err_chk(input logic ew, input logic er);
        bus(1'b0, `STAT_OFS, 32'h0);
        `CHK("wr_err", ew, rd[`ST_WRERR_BIT])
        `CHK("rd_err", er, rd[`ST_READ_PROTECT_ERROR_FLAG_BIT])
        bus(1'b1, `STAT_OFS, 32'h110);
    endtask
    task automatic ac(input logic wr, input logic ib, input int r, input int s, input logic [1:0] e);
        sw.access(wr, ib, rgs[r], s[3:0], ok, err);
        `CHK("acc ok/err", e, {ok, err})
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, `OPTCR_OFS, 32'h0);
        `CHK("optcr rst", 32'h00FFAA0D, rd)
        bus(1'b0, 4'h1, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        bus(1'b1, `KEY_OFS, `OPT_KEY1);
        bus(1'b1, `KEY_OFS, `OPT_KEY2);
        opt_chg(ow(1'b0, 8'hFE, 8'h55, 2'h3));
        `CHK("opt l1", {1'b0, 8'hFE, 8'h55, 2'h3}, opt_active)
        bus(1'b0, `OPTCR_OFS, 32'h0);
        `CHK("optcr l1", 32'h00FE550C, rd)
        `CHK("mass", 0, mass_n)
        sw.set_path(1'b1, flash_prot_pkg::BOOT_FLASH);
        ac(1'b0, 1'b0, 0, 2, 2'b01);
        ac(1'b1, 1'b0, 0, 2, 2'b00);
        err_chk(1'b1, 1'b0);
        sw.set_path(1'b0, flash_prot_pkg::BOOT_RAM);
        ac(1'b0, 1'b0, 0, 2, 2'b01);
        sw.set_path(1'b0, flash_prot_pkg::BOOT_FLASH);
        ac(1'b0, 1'b0, 0, 2, 2'b10);
        ac(1'b1, 1'b0, 0, 2, 2'b10);
        wait_idle();
        `CHK("prog sector", 4'h2, last_sec)
        foreach (ers[i]) begin
            bus(1'b1, `CTRL_OFS, ers[i]);
            err_chk(1'b1, 1'b0);
        end
        bus(1'b1, `CTRL_OFS, 32'h10012);
        bus(1'b0, `STAT_OFS, 32'h0);
        `CHK("busy", 1'b1, rd[`ST_BUSY_BIT])
        wait_idle();
        err_chk(1'b0, 1'b0);
        opt_chg(ow(1'b0, 8'hFE, 8'hAA, 2'h3));
        `CHK("mass", 1, mass_n)
        `CHK("opt l0", {1'b0, 8'hFE, 8'hAA, 2'h3}, opt_active)
        sw.set_path(1'b1, flash_prot_pkg::BOOT_RAM);
        ac(1'b0, 1'b0, 0, 2, 2'b10);
        foreach (rgs[i]) begin
            ac(1'b1, 1'b0, i, 0, 2'b00);
            err_chk(1'b1, 1'b0);
        end
        opt_chg(ow(1'b1, 8'h01, 8'hAA, 2'h3));
        ac(1'b0, 1'b0, 0, 0, 2'b01);
        err_chk(1'b0, 1'b1);
        err_chk(1'b0, 1'b0);
        ac(1'b0, 1'b1, 0, 0, 2'b10);
        ac(1'b0, 1'b0, 0, 1, 2'b10);
        ac(1'b1, 1'b0, 0, 0, 2'b00);
        err_chk(1'b1, 1'b0);
        opt_chg(ow(1'b0, 8'h01, 8'hAA, 2'h3));
        err_chk(1'b1, 1'b0);
        `CHK("spr kept", 1'b1, opt_active.spr)
        opt_chg(ow(1'b1, 8'h01, 8'hAA, 2'h1));
        `CHK("bor", 2'h1, opt_active.bor)
        sw.set_path(1'b0, flash_prot_pkg::BOOT_FLASH);
        opt_chg(ow(1'b1, 8'h01, 8'hCC, 2'h1));
        `CHK("lvl2 outs", 2'b11, {debug_disable, boot_ram_forbid})
        `CHK("mass", 1, mass_n)
        opt_chg(ow(1'b1, 8'h01, 8'h55, 2'h2));
        err_chk(1'b1, 1'b0);
        `CHK("opt l2", {1'b1, 8'h01, 8'hCC, 2'h1}, opt_active)
        sw.set_path(1'b1, flash_prot_pkg::BOOT_FLASH);
        ac(1'b0, 1'b0, 0, 1, 2'b01);
        summarize();
    end
endmodule // tb
